// *** servo_io_pkg.sv ***
/*
  Constants, codes and carriers for the servo digital I/O mapping block.
  Assumes one 16-bit object register port and a single system clock.
*/
`default_nettype none
package servo_io_pkg;
  // ----------------------------------------------------------------
  // Port counts
  // ----------------------------------------------------------------
  localparam int N_IN = 4;
  localparam int N_OUT = 2;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_IN_POL = 16'h0810;
  localparam logic [15:0] OFS_IN_SIM = 16'h0820;
  localparam logic [15:0] OFS_IN1_SEL = 16'h0830;
  localparam logic [15:0] OFS_IN2_SEL = 16'h0840;
  localparam logic [15:0] OFS_IN3_SEL = 16'h0850;
  localparam logic [15:0] OFS_IN4_SEL = 16'h0860;
  localparam logic [15:0] OFS_IN_STATE = 16'h08a0;
  localparam logic [15:0] OFS_OUT_POL = 16'h08d0;
  localparam logic [15:0] OFS_OUT_SIM = 16'h08e0;
  localparam logic [15:0] OFS_OUT1_SEL = 16'h08f0;
  localparam logic [15:0] OFS_OUT2_SEL = 16'h0900;
  localparam logic [15:0] OFS_OUT_STATE = 16'h0940;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_POL = 16'hffff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_OUT1_SEL = 16'h0001;
  localparam logic [15:0] RST_OUT2_SEL = 16'h0002;
  localparam logic [15:0] RST_OUT_STATE = 16'h000a;
  // ----------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------
  localparam logic [15:0] CW_DISABLED = 16'h0006;
  localparam int CW_RESET_ERR_BIT = 7;
  // ----------------------------------------------------------------
  // Input function codes
  // ----------------------------------------------------------------
  localparam logic [15:0] FI_ENABLE = 16'h0001;
  localparam logic [15:0] FI_RESET_ERR = 16'h0002;
  localparam logic [15:0] FI_MODE = 16'h0004;
  localparam logic [15:0] FI_KVI_OFF = 16'h0008;
  localparam logic [15:0] FI_POS_LIM = 16'h0010;
  localparam logic [15:0] FI_NEG_LIM = 16'h0020;
  localparam logic [15:0] FI_HOME = 16'h0040;
  localparam logic [15:0] FI_INV_DIR = 16'h0080;
  localparam logic [15:0] FI_SPD_IDX0 = 16'h0100;
  localparam logic [15:0] FI_SPD_IDX1 = 16'h0200;
  localparam logic [15:0] FI_POS_IDX0 = 16'h0400;
  localparam logic [15:0] FI_POS_IDX1 = 16'h0800;
  localparam logic [15:0] FI_QSTOP = 16'h1000;
  localparam logic [15:0] FI_START_HOME = 16'h2000;
  localparam logic [15:0] FI_ACTIVATE = 16'h4000;
  localparam logic [15:0] FI_SPD_IDX2 = 16'h8001;
  localparam logic [15:0] FI_POS_IDX2 = 16'h8002;
  localparam logic [15:0] FI_MULTI0 = 16'h8004;
  localparam logic [15:0] FI_MULTI1 = 16'h8008;
  localparam logic [15:0] FI_MULTI2 = 16'h8010;
  localparam logic [15:0] FI_GAIN0 = 16'h8020;
  localparam logic [15:0] FI_GAIN1 = 16'h8040;
  localparam logic [15:0] FI_MAX_CUR = 16'h8080;
  localparam logic [15:0] FI_MOTOR_ERR = 16'h8100;
  localparam logic [15:0] FI_PRE_ENABLE = 16'h8200;
  localparam logic [15:0] FI_CAPTURE1 = 16'h8400;
  localparam logic [15:0] FI_CAPTURE2 = 16'h8800;
  // ----------------------------------------------------------------
  // Output function codes
  // ----------------------------------------------------------------
  localparam logic [15:0] FO_READY = 16'h0001;
  localparam logic [15:0] FO_ERROR = 16'h0002;
  localparam logic [15:0] FO_POS_REACHED = 16'h0004;
  localparam logic [15:0] FO_ZERO_SPEED = 16'h0008;
  localparam logic [15:0] FO_BRAKE = 16'h0010;
  localparam logic [15:0] FO_SPD_REACHED = 16'h0020;
  localparam logic [15:0] FO_INDEX = 16'h0040;
  localparam logic [15:0] FO_SPD_LIMIT = 16'h0080;
  localparam logic [15:0] FO_ENABLED = 16'h0100;
  localparam logic [15:0] FO_POS_LIMIT = 16'h0200;
  localparam logic [15:0] FO_HOME_FOUND = 16'h0400;
  localparam logic [15:0] FO_TRQ_LIMIT = 16'h0800;
  localparam logic [15:0] FO_MULTI0 = 16'h1000;
  localparam logic [15:0] FO_MULTI1 = 16'h2000;
  localparam logic [15:0] FO_MULTI2 = 16'h4000;
  localparam logic [15:0] FO_SAFE_TORQUE_OFF = 16'h8001;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ready;
    logic error;
    logic pos_reached;
    logic zero_speed;
    logic brake;
    logic speed_reached;
    logic index_seen;
    logic speed_limit;
    logic enabled;
    logic pos_limit;
    logic home_found;
    logic torque_limit;
    logic [2:0] multi_out;
    logic safe_torque_off;
  } drive_status_s;

  typedef struct packed {
    logic enable;
    logic reset_errors;
    logic mode_select;
    logic kvi_off;
    logic pos_limit_active;
    logic neg_limit_active;
    logic home_switch;
    logic invert_dir;
    logic [2:0] speed_index;
    logic [2:0] pos_index;
    logic quick_stop;
    logic start_homing;
    logic activate;
    logic [2:0] multi_in;
    logic [1:0] gain_switch;
    logic max_current_toggle;
    logic motor_error;
    logic pre_enable_alarm;
  } in_func_s;

  typedef struct packed {
    logic [15:0] in_pol;
    logic [15:0] in_sim;
    logic [N_IN-1:0][15:0] in_sel;
    logic [15:0] out_pol;
    logic [15:0] out_sim;
    logic [N_OUT-1:0][15:0] out_sel;
    logic [15:0] in_state;
    logic [15:0] out_state;
    logic [N_OUT-1:0] pins;
    in_func_s func;
    logic [15:0] cw;
    logic [1:0] cap_lvl;
    logic [1:0] cap_pulse;
    logic [15:0] rdata;
    logic ack;
    logic err;
  } io_state_s;
endpackage
`default_nettype wire

// *** servo_io_map.sv ***
/*
  Digital I/O function mapping of a servo drive: input decode, output
  select, polarity, simulation, status words and the object register port.
  Assumes pins already synchronous to i_sys_clk and a drive core that
  supplies status conditions and the input-selected control word.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_io_map (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [servo_io_pkg::N_IN-1:0] i_input_pin,
  input wire servo_io_pkg::drive_status_s i_status,
  input wire logic [15:0] i_sel_control_word,
  input wire logic i_reg_req,
  input wire logic i_reg_we,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_reg_err,
  output logic [servo_io_pkg::N_OUT-1:0] o_output_pin,
  output servo_io_pkg::in_func_s o_func,
  output logic [15:0] o_control_word,
  output logic [1:0] o_capture_trig
);
  localparam int NI = servo_io_pkg::N_IN;
  localparam int NO = servo_io_pkg::N_OUT;
  // Offset that no register decodes, used by the refusal check
  localparam logic [15:0] UNMAPPED_ADDR = 16'h0870;

  servo_io_pkg::io_state_s q;
  servo_io_pkg::io_state_s d;
  logic [NI-1:0] eff;
  logic [NO-1:0] out_lvl;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // High when any input selecting code has its level high
  function automatic logic in_match(
    input logic [NI-1:0][15:0] sel,
    input logic [NI-1:0] lvl,
    input logic [15:0] code
  );
    logic r;
    r = 1'b0;
    for (int i = 0; i < NI; i++) begin
      r = r | ((sel[i] == code) & lvl[i]);
    end
    return r;
  endfunction

  function automatic logic out_cond(
    input servo_io_pkg::drive_status_s s,
    input logic [15:0] code
  );
    logic r;
    r = 1'b0;
    case (code)
      servo_io_pkg::FO_READY: r = s.ready;
      servo_io_pkg::FO_ERROR: r = s.error;
      servo_io_pkg::FO_POS_REACHED: r = s.pos_reached;
      servo_io_pkg::FO_ZERO_SPEED: r = s.zero_speed;
      servo_io_pkg::FO_BRAKE: r = s.brake;
      servo_io_pkg::FO_SPD_REACHED: r = s.speed_reached;
      servo_io_pkg::FO_INDEX: r = s.index_seen;
      servo_io_pkg::FO_SPD_LIMIT: r = s.speed_limit;
      servo_io_pkg::FO_ENABLED: r = s.enabled;
      servo_io_pkg::FO_POS_LIMIT: r = s.pos_limit;
      servo_io_pkg::FO_HOME_FOUND: r = s.home_found;
      servo_io_pkg::FO_TRQ_LIMIT: r = s.torque_limit;
      servo_io_pkg::FO_MULTI0: r = s.multi_out[0];
      servo_io_pkg::FO_MULTI1: r = s.multi_out[1];
      servo_io_pkg::FO_MULTI2: r = s.multi_out[2];
      servo_io_pkg::FO_SAFE_TORQUE_OFF: r = s.safe_torque_off;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic servo_io_pkg::io_state_s reset_state();
    servo_io_pkg::io_state_s s;
    s = '0;
    s.in_pol = servo_io_pkg::RST_POL;
    s.in_sim = servo_io_pkg::RST_ZERO;
    for (int i = 0; i < NI; i++) begin
      s.in_sel[i] = servo_io_pkg::RST_ZERO;
    end
    s.out_pol = servo_io_pkg::RST_POL;
    s.out_sim = servo_io_pkg::RST_ZERO;
    s.out_sel[0] = servo_io_pkg::RST_OUT1_SEL;
    s.out_sel[1] = servo_io_pkg::RST_OUT2_SEL;
    s.in_state = servo_io_pkg::RST_ZERO;
    s.out_state = servo_io_pkg::RST_OUT_STATE;
    s.cw = servo_io_pkg::CW_DISABLED;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Effective levels
  // ----------------------------------------------------------------
  always_comb begin
    eff = (i_input_pin ^ q.in_pol[NI-1:0])
      | q.in_sim[NI-1:0];
    for (int i = 0; i < NO; i++) begin
      // Output polarity bit set keeps the condition non-inverted
      out_lvl[i] = (out_cond(i_status, q.out_sel[i]) ^ ~q.out_pol[i])
        | q.out_sim[i];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Input function decode
    d.func.enable = in_match(q.in_sel, eff, servo_io_pkg::FI_ENABLE);
    d.func.reset_errors = in_match(q.in_sel, eff,
      servo_io_pkg::FI_RESET_ERR);
    d.func.mode_select = in_match(q.in_sel, eff, servo_io_pkg::FI_MODE);
    d.func.kvi_off = in_match(q.in_sel, eff, servo_io_pkg::FI_KVI_OFF);
    d.func.pos_limit_active = in_match(q.in_sel, ~eff,
      servo_io_pkg::FI_POS_LIM);
    d.func.neg_limit_active = in_match(q.in_sel, ~eff,
      servo_io_pkg::FI_NEG_LIM);
    d.func.home_switch = in_match(q.in_sel, eff, servo_io_pkg::FI_HOME);
    d.func.invert_dir = in_match(q.in_sel, eff, servo_io_pkg::FI_INV_DIR);
    d.func.speed_index = {
      in_match(q.in_sel, eff, servo_io_pkg::FI_SPD_IDX2),
      in_match(q.in_sel, eff, servo_io_pkg::FI_SPD_IDX1),
      in_match(q.in_sel, eff, servo_io_pkg::FI_SPD_IDX0)};
    d.func.pos_index = {
      in_match(q.in_sel, eff, servo_io_pkg::FI_POS_IDX2),
      in_match(q.in_sel, eff, servo_io_pkg::FI_POS_IDX1),
      in_match(q.in_sel, eff, servo_io_pkg::FI_POS_IDX0)};
    d.func.quick_stop = in_match(q.in_sel, eff, servo_io_pkg::FI_QSTOP);
    d.func.start_homing = in_match(q.in_sel, eff,
      servo_io_pkg::FI_START_HOME);
    d.func.activate = in_match(q.in_sel, eff, servo_io_pkg::FI_ACTIVATE);
    d.func.multi_in = {
      in_match(q.in_sel, eff, servo_io_pkg::FI_MULTI2),
      in_match(q.in_sel, eff, servo_io_pkg::FI_MULTI1),
      in_match(q.in_sel, eff, servo_io_pkg::FI_MULTI0)};
    d.func.gain_switch = {
      in_match(q.in_sel, eff, servo_io_pkg::FI_GAIN1),
      in_match(q.in_sel, eff, servo_io_pkg::FI_GAIN0)};
    d.func.max_current_toggle = in_match(q.in_sel, eff,
      servo_io_pkg::FI_MAX_CUR);
    d.func.motor_error = in_match(q.in_sel, eff,
      servo_io_pkg::FI_MOTOR_ERR);
    d.func.pre_enable_alarm = in_match(q.in_sel, {NI{1'b1}},
      servo_io_pkg::FI_PRE_ENABLE) & ~d.func.enable;
    // Control word follows the enable function
    d.cw = d.func.enable ? i_sel_control_word
      : servo_io_pkg::CW_DISABLED;
    if (d.func.reset_errors) begin
      d.cw[servo_io_pkg::CW_RESET_ERR_BIT] = 1'b1;
    end
    // Capture triggers fire on the rising effective level
    d.cap_lvl = {
      in_match(q.in_sel, eff, servo_io_pkg::FI_CAPTURE2),
      in_match(q.in_sel, eff, servo_io_pkg::FI_CAPTURE1)};
    d.cap_pulse = d.cap_lvl & ~q.cap_lvl;
    // Pins and status words
    d.pins = out_lvl;
    d.in_state = '0;
    d.in_state[NI-1:0] = eff;
    d.out_state = '0;
    d.out_state[NO-1:0] = out_lvl;
    // Register port
    d.ack = i_reg_req;
    d.err = 1'b0;
    d.rdata = q.rdata;
    if (i_reg_req) begin
      d.rdata = '0;
      if (i_reg_addr == servo_io_pkg::OFS_IN_POL) begin
        d.rdata = q.in_pol;
        if (i_reg_we) d.in_pol = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_IN_SIM) begin
        d.rdata = q.in_sim;
        if (i_reg_we) d.in_sim = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_IN1_SEL) begin
        d.rdata = q.in_sel[0];
        if (i_reg_we) d.in_sel[0] = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_IN2_SEL) begin
        d.rdata = q.in_sel[1];
        if (i_reg_we) d.in_sel[1] = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_IN3_SEL) begin
        d.rdata = q.in_sel[2];
        if (i_reg_we) d.in_sel[2] = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_IN4_SEL) begin
        d.rdata = q.in_sel[3];
        if (i_reg_we) d.in_sel[3] = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_IN_STATE) begin
        d.rdata = q.in_state;
        d.err = i_reg_we;
      end else if (i_reg_addr == servo_io_pkg::OFS_OUT_POL) begin
        d.rdata = q.out_pol;
        if (i_reg_we) d.out_pol = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_OUT_SIM) begin
        d.rdata = q.out_sim;
        if (i_reg_we) d.out_sim = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_OUT1_SEL) begin
        d.rdata = q.out_sel[0];
        if (i_reg_we) d.out_sel[0] = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_OUT2_SEL) begin
        d.rdata = q.out_sel[1];
        if (i_reg_we) d.out_sel[1] = i_reg_wdata;
      end else if (i_reg_addr == servo_io_pkg::OFS_OUT_STATE) begin
        d.rdata = q.out_state;
        d.err = i_reg_we;
      end else begin
        d.err = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      q <= reset_state();
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_reg_ack = q.ack & i_clk_en;
  assign o_reg_err = q.err & q.ack & i_clk_en;
  assign o_output_pin = q.pins;
  assign o_func = q.func;
  assign o_control_word = q.cw;
  assign o_capture_trig = q.cap_pulse;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  enable_decode_a: assert property (
    i_clk_en && q.in_sel[0] == servo_io_pkg::FI_ENABLE && eff[0]
    |=> o_func.enable)
    else $error("enable input not decoded");

  cw_disabled_a: assert property (
    !o_func.enable && !o_func.reset_errors
    |-> o_control_word == servo_io_pkg::CW_DISABLED)
    else $error("control word not forced while disabled");

  cw_follow_a: assert property (
    i_clk_en && d.func.enable && !d.func.reset_errors
    |=> o_control_word == $past(i_sel_control_word))
    else $error("control word not taken from selection");

  quick_stop_a: assert property (
    i_clk_en && q.in_sel[0] == servo_io_pkg::FI_QSTOP && eff[0]
    |=> o_func.quick_stop)
    else $error("quick stop decode wrong");

  ext_index_a: assert property (
    i_clk_en && q.in_sel[0] == servo_io_pkg::FI_SPD_IDX2 && eff[0]
    |=> o_func.speed_index[2] && (!o_func.pos_index[2] ||
      $past(q.in_sel[1]) == servo_io_pkg::FI_POS_IDX2 ||
      $past(q.in_sel[2]) == servo_io_pkg::FI_POS_IDX2 ||
      $past(q.in_sel[3]) == servo_io_pkg::FI_POS_IDX2))
    else $error("speed index 2 decode wrong");

  motor_error_a: assert property (
    i_clk_en && q.in_sel[0] == servo_io_pkg::FI_MOTOR_ERR && eff[0]
    |=> o_func.motor_error)
    else $error("motor error input lost");

  pre_enable_a: assert property (
    i_clk_en && q.in_sel[0] == servo_io_pkg::FI_PRE_ENABLE &&
    !d.func.enable |=> o_func.pre_enable_alarm)
    else $error("pre-enable alarm missing");

  capture_pulse_a: assert property (
    o_capture_trig[0] && i_clk_en |=> !o_capture_trig[0])
    else $error("capture trigger longer than a cycle");

  out_ready_a: assert property (
    i_clk_en && q.out_sel[0] == servo_io_pkg::FO_READY && !q.out_sim[0]
    |=> o_output_pin[0] == ($past(i_status.ready) ^ ~$past(q.out_pol[0])))
    else $error("ready output wrong");

  out_sim_a: assert property (
    i_clk_en && q.out_sim[0] |=> o_output_pin[0])
    else $error("output simulation not forcing");

  in_state_a: assert property (
    i_clk_en |=> q.in_state[NI-1:0] ==
      (($past(i_input_pin) ^ $past(q.in_pol[NI-1:0]))
      | $past(q.in_sim[NI-1:0])))
    else $error("input status word wrong");

  pos_limit_a: assert property (
    i_clk_en && q.in_sel[0] == servo_io_pkg::FI_POS_LIM && !eff[0]
    |=> o_func.pos_limit_active)
    else $error("positive limit not active on low level");

  bad_addr_a: assert property (
    i_clk_en && i_reg_req && i_reg_addr == UNMAPPED_ADDR ##1 i_clk_en
    |-> o_reg_ack && o_reg_err)
    else $error("unmapped address not refused");

  freeze_state_a: assert property (
    !i_clk_en |=> $stable(q))
    else $error("state moved while clock enable low");

  out_state_a: assert property (
    i_clk_en |=> q.out_state[NO-1:0] == $past(out_lvl))
    else $error("output status word wrong");

  enable_cov: cover property (
    i_clk_en && d.func.enable ##1 o_control_word == i_sel_control_word);
  capture_cov: cover property (o_capture_trig[1]);
  pre_alarm_cov: cover property (o_func.pre_enable_alarm);
  sel_write_cov: cover property (
    i_clk_en && i_reg_req && i_reg_we &&
    i_reg_addr == servo_io_pkg::OFS_OUT1_SEL);
endmodule
`default_nettype wire

// *** servo_io_far_side.sv ***
/*
  Far-side model: contacts of switches and sensors wired to the inputs.
  Assumes the bench sets contact states at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_io_far_side (
  input wire logic [servo_io_pkg::N_IN-1:0] i_contact,
  output logic [servo_io_pkg::N_IN-1:0] o_input_pin
);
  // ------------------------------------------------------------
  // Contact levels
  // ------------------------------------------------------------
  // Limit switches are normally closed: an open contact reads low
  assign o_input_pin = i_contact;
endmodule
`default_nettype wire

// *** servo_io_map_tb_top.sv ***
/*
  Self-checking bench for servo_io_map: registers, input and output codes.
  Assumes a 125 MHz clock and the far-side contact model.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_io_map_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] sel_cw = 16'h0000;
  logic [3:0] contact = 4'h0;
  servo_io_pkg::drive_status_s status = '0;
  logic [3:0] pin;
  logic [15:0] rdata;
  logic [15:0] cw;
  logic [15:0] rd;
  logic [15:0] code;
  logic [1:0] opin;
  logic [1:0] cap;
  logic [24:0] e;
  logic ack;
  logic err;
  logic rerr;
  servo_io_pkg::in_func_s func;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  int b;
  localparam logic [15:0] ra [10] = '{16'h0810, 16'h0820, 16'h0830,
    16'h0840, 16'h0850, 16'h0860, 16'h08d0, 16'h08e0, 16'h08f0, 16'h0900};
  localparam logic [15:0] rv [10] = '{16'hffff, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0001, 16'h0002};
  // Bit of in_func_s raised by each code, -1 for capture codes
  localparam int fb [27] = '{24, 23, 22, 21, 20, 19, 18, 17, 14, 15, 11,
    12, 10, 9, 8, 16, 13, 5, 6, 7, 3, 4, 2, 1, 0, -1, -1};

  servo_io_far_side far (.i_contact(contact), .o_input_pin(pin));
  servo_io_map dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_clk_en(clk_en),
    .i_input_pin(pin), .i_status(status), .i_sel_control_word(sel_cw),
    .i_reg_req(req), .i_reg_we(we), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .o_reg_err(err), .o_output_pin(opin), .o_func(func),
    .o_control_word(cw), .o_capture_trig(cap));

  // ------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ------------------------------------------------------------
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request, released once the answer cycle has been reached
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d);
    @(negedge sys_clk);
    req = 1'b1;
    we = w;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    req = 1'b0;
    rd = rdata;
    rerr = err;
    chk(32'(ack), 32'h0000_0001);
  endtask
  task automatic settle();
    repeat (3) @(negedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, ra[i], 16'h0000);
      chk({rerr, rd}, 32'(rv[i]));
    end
    acc(1'b0, 16'h0870, 16'h0000);
    chk({rerr, rd}, 32'h0001_0000);
    acc(1'b1, 16'h08a0, 16'h00ff);
    chk(32'(rerr), 32'h0000_0001);
    acc(1'b1, 16'h0810, 16'h0000);
    for (int j = 0; j < 27; j++) begin
      code = (j < 15) ? 16'h0001 << j : 16'h8000 | (16'h0001 << (j - 15));
      acc(1'b1, 16'h0830, code);
      e = (fb[j] < 0) ? 25'h0 : 25'h1 << fb[j];
      contact = 4'h1;
      settle();
      chk(32'(func), (j == 4 || j == 5) ? 0 : 32'(e));
      contact = 4'h0;
      settle();
      chk(32'(func), (j == 4 || j == 5 || j == 24) ? 32'(e) : 0);
    end
    for (int ch = 0; ch < 2; ch++) begin
      acc(1'b1, 16'h0830, (ch == 0) ? 16'h8400 : 16'h8800);
      settle();
      contact = 4'h1;
      n = 0;
      repeat (5) begin
        @(negedge sys_clk);
        n += (cap === (2'b01 << ch));
      end
      chk(32'(n), 32'h0000_0001);
      contact = 4'h0;
    end
    acc(1'b1, 16'h0830, 16'h0001);
    sel_cw = 16'h1234;
    contact = 4'h1;
    settle();
    chk(32'(cw), 32'h0000_1234);
    acc(1'b0, 16'h08a0, 16'h0000);
    chk(32'(rd), 32'h0000_0001);
    contact = 4'h0;
    settle();
    chk(32'(cw), 32'h0000_0006);
    acc(1'b1, 16'h0820, 16'h0001);
    settle();
    chk(32'(cw), 32'h0000_1234);
    acc(1'b1, 16'h0820, 16'h0000);
    acc(1'b1, 16'h0810, 16'h0001);
    settle();
    chk(32'(func.enable), 32'h0000_0001);
    clk_en = 1'b0;
    contact = 4'h1;
    settle();
    chk(32'(cw), 32'h0000_1234);
    clk_en = 1'b1;
    settle();
    chk(32'(cw), 32'h0000_0006);
    contact = 4'h0;
    for (int k = 0; k < 16; k++) begin
      code = (k < 15) ? 16'h0001 << k : 16'h8001;
      b = (k < 12) ? 15 - k : ((k < 15) ? k - 11 : 0);
      acc(1'b1, 16'h08f0, code);
      status = servo_io_pkg::drive_status_s'(~(16'h0001 << b));
      settle();
      chk(32'(opin[0]), 32'h0000_0000);
      status = servo_io_pkg::drive_status_s'(16'h0001 << b);
      settle();
      chk(32'(opin[0]), 32'h0000_0001);
    end
    acc(1'b0, 16'h0940, 16'h0000);
    chk(32'(rd[0]), 32'h0000_0001);
    status = '0;
    acc(1'b1, 16'h08e0, 16'h0001);
    settle();
    chk(32'(opin[0]), 32'h0000_0001);
    status.error = 1'b1;
    settle();
    chk(32'(opin[1]), 32'h0000_0001);
    acc(1'b1, 16'h08d0, 16'hfffd);
    settle();
    chk(32'(opin[1]), 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
